// File: bench/reading_store_and_recall_bench.sv
// bench for the store: register tasks, pin pulses and expected values
// assumes a shortened millisecond tick of ten clocks
`timescale 1ns/1ns
module reading_store_and_recall_bench;
  import rsr_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_valid;
  logic trig_key_pin, ext_trig_pin, store_lamp, recall_lamp, short_period, l0;
  logic [31:0] haddr, hwdata, hrdata, got;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rsr_reading_t rd, val, shown_reading;
  rsr_meas_t meas;
  int errors, comparisons, n;
  rsr_reading_t vals [4] = '{25'h0000007, 25'h0FFFFFC, 25'h0000002, 25'h1000064};
  logic [31:0] sdat [3] = '{32'h7, 32'hFFFFFFFC, 32'h1};
  logic [31:0] saux [3] = '{32'h601, 32'h602, 32'h603};
  assign hready = hreadyout;
  rsr_store #(.TICK_CYC(10), .DEPTH(500)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .rd_valid, .rd,
    .meas, .trig_key_pin, .ext_trig_pin, .store_lamp, .recall_lamp, .short_period,
    .shown_reading);
  rsr_core_model core (.hclk, .hresetn, .val, .rd_valid, .rd);
  // 25 MHz clock
  always #20 hclk = ~hclk;
  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one edge, then bounded wait for the slave's ready
  task automatic wait_rdy();
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(posedge hclk);
    end
    if (n >= 50) begin
      errors++;
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    got = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, got & m);
  endtask
  task automatic cmd(input int b);
    xfer(1'b1, RSR_A_CMD, 32'h1 << b);
  endtask
  // pin pulse long enough for the synchroniser and one core offer
  task automatic pulse(input logic ext);
    if (ext) ext_trig_pin <= 1'b1;
    else trig_key_pin <= 1'b1;
    repeat (8) @(posedge hclk);
    ext_trig_pin <= 1'b0;
    trig_key_pin <= 1'b0;
    repeat (20) @(posedge hclk);
  endtask
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  // main sequence
  initial begin
    {hclk, hsel, hwrite, htrans, trig_key_pin, ext_trig_pin} = '0;
    {haddr, hwdata, errors, comparisons} = '0;
    hsize = 3'h2;
    val = '0;
    meas = '0;
    meas.func_ok = 1'b1;
    meas.func = 4'h5;
    meas.bus_addr = 5'h0A;
    meas.range = 3'h3;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rc("interval", RSR_A_IVL, 32'hFFFFFFFF, 32'h000003E8);
    rc("size", RSR_A_SIZE, 32'hFFFFFFFF, 32'h00000064);
    rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    done("reset");
    cmd(RSR_C_OPEN);
    xfer(1'b1, RSR_A_IVL, 32'h0);
    xfer(1'b1, RSR_A_SIZE, 32'h258);
    rc("size clamp", RSR_A_SIZE, 32'hFFFFFFFF, 32'h1F4);
    xfer(1'b1, RSR_A_SIZE, 32'h4);
    cmd(RSR_C_ENTER);
    rc("armed", RSR_A_STAT, 32'h7, 32'h2);
    l0 = store_lamp;
    n = 0;
    while (store_lamp === l0 && n < 3000) begin
      n++;
      @(posedge hclk);
    end
    chk("armed blink", 32'h1, {31'h0, n < 3000});
    if (n >= 3000) begin
      summarize();
    end
    pulse(1'b0);
    // range moves after start; recall must keep the captured one
    meas.range <= 3'h5;
    for (int i = 0; i < 4; i++) begin
      val <= vals[i];
      pulse(1'b1);
    end
    rc("full", RSR_A_STAT, 32'h0FF80017, 32'h00200014);
    chk("shown", 32'h01000064, 32'(shown_reading));
    done("one-shot");
    cmd(RSR_C_RECALL);
    rc("recall loc", RSR_A_LOC, 32'h1FF, 32'h4);
    cmd(RSR_C_UP);
    rc("wrap up", RSR_A_LOC, 32'h1FF, 32'h1);
    cmd(RSR_C_DOWN);
    rc("wrap down", RSR_A_LOC, 32'h1FF, 32'h4);
    xfer(1'b1, RSR_A_LOC, 32'h9);
    rc("loc clamp", RSR_A_LOC, 32'h1FF, 32'h4);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, RSR_A_SEL, {29'h0, RSR_S_MAX} + i);
      rc("stat value", RSR_A_DATA, 32'hFFFFFFFF, sdat[i]);
      rc("stat place", RSR_A_AUX, 32'hFFF, saux[i]);
    end
    xfer(1'b1, RSR_A_SEL, 32'h0);
    rc("entry func", RSR_A_DATA, 32'hFFFFFFFF, 32'h5);
    cmd(RSR_C_UP);
    rc("entry addr", RSR_A_DATA, 32'hFFFFFFFF, 32'hA);
    rc("entry index", RSR_A_AUX, 32'hF, 32'h1);
    cmd(RSR_C_FUNC);
    rc("func in recall", RSR_A_STAT, 32'h27, 32'h24);
    cmd(RSR_C_RESET);
    cmd(RSR_C_FUNC);
    rc("func stop", RSR_A_STAT, 32'h27, 32'h0);
    done("recall");
    cmd(RSR_C_OPEN);
    xfer(1'b1, RSR_A_IVL, 32'h2);
    xfer(1'b1, RSR_A_SIZE, 32'h0);
    cmd(RSR_C_ENTER);
    rc("fast ring refused", RSR_A_STAT, 32'h7, 32'h1);
    cmd(RSR_C_RESET);
    rc("cfg abort", RSR_A_STAT, 32'h7, 32'h0);
    cmd(RSR_C_OPEN);
    xfer(1'b1, RSR_A_SIZE, 32'h5);
    cmd(RSR_C_ENTER);
    meas.autorange <= 1'b1;
    pulse(1'b0);
    rc("fast autorange", RSR_A_STAT, 32'h7, 32'h0);
    done("high speed");
    meas.autorange <= 1'b0;
    meas.res <= 2'h2;
    cmd(RSR_C_OPEN);
    xfer(1'b1, RSR_A_IVL, 32'hA);
    xfer(1'b1, RSR_A_SIZE, 32'h2);
    cmd(RSR_C_ENTER);
    pulse(1'b0);
    repeat (400) @(posedge hclk);
    rc("timed full", RSR_A_STAT, 32'h0FFFFC57, 32'h00100854);
    done("timed");
    summarize();
  end
endmodule

// File: bench/rsr_core_model.sv
// measurement core stand-in: offers one reading every fourth clock
// assumes the bench sets the value to offer; same clock as the store
`timescale 1ns/1ns
module rsr_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // value chosen by the bench
  input wire rsr_pkg::rsr_reading_t val,
  // towards the store
  output logic rd_valid,
  output rsr_pkg::rsr_reading_t rd
);
  import rsr_pkg::*;
  logic [1:0] cnt;
  // free-running pace; data between offers is inverted so stale use shows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 2'h0;
      rd_valid <= 1'b0;
      rd <= '0;
    end else begin
      cnt <= cnt + 2'h1;
      rd_valid <= (cnt == 2'h3);
      rd <= (cnt == 2'h3) ? val : ~val;
    end
  end
endmodule

// File: bench/rsr_store_sva.sv
// checker for the store: bus answer, recall lamp and display causes
// assumes it is bound to rsr_store and sees only its ports
`timescale 1ns/1ns
module rsr_store_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // core and display
  input wire logic rd_valid,
  input wire logic store_lamp,
  input wire logic recall_lamp,
  input wire logic short_period,
  input wire rsr_pkg::rsr_reading_t shown_reading
);
  import rsr_pkg::*;
  logic ph_q, rd_q, um_q, st_q, cmd_q;
  // data-phase tracking; qualifiers only mean something with ph_q
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ph_q, rd_q, um_q, st_q, cmd_q} <= 5'h00;
    end else begin
      ph_q <= hsel && htrans[1] && hready;
      rd_q <= !hwrite;
      um_q <= haddr > 32'h0000001C;
      st_q <= haddr[7:0] == RSR_A_STAT;
      cmd_q <= haddr[7:0] == RSR_A_CMD;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // command write and read data phases
  sequence recall_cmd;
    ph_q && !rd_q && cmd_q && hwdata[RSR_C_RECALL] && !hwdata[RSR_C_RESET];
  endsequence
  sequence read_ph;
    ph_q && rd_q;
  endsequence
  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  okay_resp_a: assert property (!hresp) else $error("error response seen");
  rdata_hold_a: assert property ($changed(hrdata) |-> read_ph)
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (ph_q && rd_q && um_q |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  stat_mirror_a: assert property (ph_q && rd_q && st_q |->
    hrdata[6:4] == $past({short_period, recall_lamp, store_lamp}))
    else $error("status bits differ from pins");
  // lamp is one register behind recall mode, which follows the data phase
  recall_on_a: assert property (recall_cmd |-> ##2 recall_lamp)
    else $error("recall lamp not lit");
  recall_off_a: assert property ($fell(recall_lamp) |->
    $past(ph_q && !rd_q && cmd_q && hwdata[RSR_C_RESET], 2))
    else $error("recall left without reset");
  shown_cause_a: assert property ($changed(shown_reading) |->
    $past(rd_valid) || $past(rd_valid, 2))
    else $error("display changed with no reading");
endmodule
bind rsr_store rsr_store_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hreadyout, .hresp, .hrdata, .rd_valid, .store_lamp, .recall_lamp,
  .short_period, .shown_reading);

// File: pkg/rsr_pkg.sv
// reading store and recall: shared constants, types and register map
// assumes one 25 MHz clock shared by bus, measurement core and this block
package rsr_pkg;
  // clock and time base
  localparam int RSR_CLK_HZ = 25_000_000;
  localparam int RSR_TICK_US = 1000;
  localparam int RSR_TICK_CYC = RSR_CLK_HZ / 1_000_000 * RSR_TICK_US;
  localparam int RSR_BLINK_MS = 250;
  // store geometry
  localparam int RSR_DEPTH = 500;
  localparam int RSR_LOC_W = 9;
  localparam int RSR_RD_W = 24;
  localparam int RSR_IVL_W = 20;
  localparam int RSR_SUM_W = 34;
  localparam logic [RSR_IVL_W-1:0] RSR_IVL_MAX = 20'hF423F;
  localparam logic [RSR_IVL_W-1:0] RSR_HS_MAX_MS = 20'h00004;
  localparam logic [RSR_IVL_W-1:0] RSR_SLOW_MS = 20'h00028;
  localparam logic [1:0] RSR_HS_RES_MAX = 2'h1;
  localparam logic [1:0] RSR_SLOW_RES_MIN = 2'h2;
  // reset values
  localparam logic [RSR_IVL_W-1:0] RSR_IVL_RST = 20'h003E8;
  localparam logic [RSR_LOC_W-1:0] RSR_SIZE_RST = 9'h064;
  // register byte offsets
  localparam logic [7:0] RSR_A_IVL = 8'h00;
  localparam logic [7:0] RSR_A_SIZE = 8'h04;
  localparam logic [7:0] RSR_A_CMD = 8'h08;
  localparam logic [7:0] RSR_A_STAT = 8'h0C;
  localparam logic [7:0] RSR_A_LOC = 8'h10;
  localparam logic [7:0] RSR_A_SEL = 8'h14;
  localparam logic [7:0] RSR_A_DATA = 8'h18;
  localparam logic [7:0] RSR_A_AUX = 8'h1C;
  // command bits
  localparam int RSR_C_OPEN = 0;
  localparam int RSR_C_ENTER = 1;
  localparam int RSR_C_RESET = 2;
  localparam int RSR_C_FUNC = 3;
  localparam int RSR_C_RECALL = 4;
  localparam int RSR_C_UP = 5;
  localparam int RSR_C_DOWN = 6;
  localparam int RSR_C_NORMAL = 7;
  // recall selector codes
  localparam logic [2:0] RSR_S_STATUS = 3'h0;
  localparam logic [2:0] RSR_S_MAX = 3'h1;
  localparam logic [2:0] RSR_S_MIN = 3'h2;
  localparam logic [2:0] RSR_S_MEAN = 3'h3;
  localparam logic [2:0] RSR_S_NORMAL = 3'h4;
  localparam logic [3:0] RSR_ENTRIES = 4'hB;
  typedef enum logic [2:0] {RSR_IDLE, RSR_CFG, RSR_ARMED, RSR_STORING, RSR_FULL} rsr_state_t;
  typedef struct packed {
    logic ovr;
    logic signed [RSR_RD_W-1:0] value;
  } rsr_reading_t;
  typedef struct packed {
    logic func_ok;
    logic autorange;
    logic [1:0] res;
    logic [2:0] range;
    logic [3:0] func;
    logic [4:0] bus_addr;
    logic freq;
    logic mux;
    logic scale_offset_math;
    logic [31:0] m_val;
    logic [31:0] b_val;
    logic [31:0] ref_val;
    logic [6:0] filter;
    logic zero_on;
    logic [31:0] zero_val;
  } rsr_meas_t;
endpackage

// File: src/rsr_store.sv
// reading store and recall, AHB-Lite slave with 500-location store
// assumes readings and settings come from the core on hclk; the trigger key is a pin, other keys are command bits
// Contract
// [RULE1] interval zero means trigger paced one-shot
// [RULE2] stop when stored count reaches size
// [RULE3] size zero wraps after location 500
// [RULE4] size above 500 clamps to 500
// [RULE5] high speed needs size 1..500
// [RULE6] high speed start checks function, autorange, resolution
// [RULE7] reset before confirm aborts configuration
// [RULE8] armed waits for trigger, indicator blinks
// [RULE9] timed storage flashes, steady when full
// [RULE10] one-shot key press stores one reading
// [RULE11] one-shot external pulse stores one reading
// [RULE12] too slow flags short period, stores anyway
// [RULE13] start overwrites from location 1, no clear
// [RULE14] function key stops store, recall needs reset
// [RULE15] recall shows range captured at start
// [RULE16] recall entry shows last stored location
// [RULE17] location request clamps to size
// [RULE18] recall stepping wraps both ways
// [RULE19] selector 1 max, 2 min with location
// [RULE20] selector 3 mean, count, overrange excluded
// [RULE21] statistics follow every new reading
// [RULE22] selector 0 steps captured settings
// [RULE23] interval spans 1 ms to 999.999 s
// [RULE24] intervals 1 to 4 ms are high speed
// [RULE25] high resolution under 40 ms is short period
// [RULE26] millisecond tick timer reloads interval
`timescale 1ns/1ns
module rsr_store #(
  parameter int TICK_CYC = rsr_pkg::RSR_TICK_CYC,
  parameter int DEPTH = rsr_pkg::RSR_DEPTH
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // measurement core
  input wire logic rd_valid,
  input wire rsr_pkg::rsr_reading_t rd,
  input wire rsr_pkg::rsr_meas_t meas,
  // front panel pins
  input wire logic trig_key_pin,
  input wire logic ext_trig_pin,
  // indicators and display
  output logic store_lamp,
  output logic recall_lamp,
  output logic short_period,
  output rsr_pkg::rsr_reading_t shown_reading
);
  import rsr_pkg::*;

  // elaboration check: values the store logic cannot serve
  if (TICK_CYC < 1 || DEPTH < 1 || DEPTH > RSR_DEPTH) begin : g_bad_param
    $error("rsr_store: bad parameter");
  end

  localparam logic [RSR_LOC_W-1:0] DEPTH_L = RSR_LOC_W'(DEPTH);
  localparam logic [RSR_LOC_W-1:0] ONE_L = 9'h001;

  rsr_state_t state;
  rsr_reading_t mem [DEPTH];
  rsr_meas_t capt;
  logic [RSR_IVL_W-1:0] ivl;
  logic [RSR_LOC_W-1:0] size;
  logic [RSR_LOC_W-1:0] wr_ptr, filled, last_loc, location_prompt, max_loc, min_loc, cnt;
  logic [RSR_LOC_W-1:0] lim;
  logic [2:0] sel;
  logic [3:0] ent;
  logic recall_on, oneshot, hs, due, shot;
  logic signed [RSR_SUM_W-1:0] sum;
  logic signed [RSR_RD_W-1:0] max_v, min_v;
  logic [31:0] tick_cnt;
  logic [RSR_IVL_W-1:0] ms_cnt;
  logic tick, expire;
  logic [7:0] blink_cnt;
  logic blink;

  // bus: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // data-phase write capture
  logic dp_wr;
  logic [7:0] dp_addr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // write decode into one-cycle commands
  logic [7:0] cmd;
  logic wr_ivl, wr_size, wr_loc, wr_sel;
  always_comb begin
    cmd = 8'h00;
    wr_ivl = 1'b0;
    wr_size = 1'b0;
    wr_loc = 1'b0;
    wr_sel = 1'b0;
    if (dp_wr) begin
      if (dp_addr == RSR_A_IVL) begin
        wr_ivl = 1'b1;
      end else if (dp_addr == RSR_A_SIZE) begin
        wr_size = 1'b1;
      end else if (dp_addr == RSR_A_CMD) begin
        cmd = hwdata[7:0];
      end else if (dp_addr == RSR_A_LOC) begin
        wr_loc = 1'b1;
      end else if (dp_addr == RSR_A_SEL) begin
        wr_sel = 1'b1;
      end
    end
  end

  // pin synchronisers, edge taken after second stage
  logic [2:0] key_s, ext_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_s <= 3'h0;
      ext_s <= 3'h0;
    end else begin
      key_s <= {key_s[1:0], trig_key_pin};
      ext_s <= {ext_s[1:0], ext_trig_pin};
    end
  end
  wire key_evt = key_s[1] && !key_s[2];
  wire ext_evt = ext_s[1] && !ext_s[2];

  // derived modes
  // [RULE1] zero interval selects one-shot
  assign oneshot = (ivl == '0);
  // [RULE24] shortest intervals are high speed
  assign hs = !oneshot && (ivl <= RSR_HS_MAX_MS);
  // [RULE3] size zero means full depth ring
  assign lim = (size == '0) ? DEPTH_L : size;

  // [RULE26] millisecond tick from system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  // start conditions
  wire start_req = (state == RSR_ARMED) && key_evt;
  // [RULE6] high speed validity at start
  wire hs_bad = hs && (size == '0 || !meas.func_ok || meas.autorange || meas.res > RSR_HS_RES_MAX);
  wire start_ok = start_req && !hs_bad;
  wire storing = (state == RSR_STORING);

  // [RULE26] interval countdown, reloaded at start and on each expiry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt <= '0;
    end else if (start_ok || expire) begin
      ms_cnt <= ivl;
    end else if (storing && tick && ms_cnt != '0) begin
      ms_cnt <= ms_cnt - 1'b1;
    end
  end
  assign expire = storing && !oneshot && tick && (ms_cnt <= RSR_IVL_W'(ONE_L));

  // storage permission: timed due or one-shot trigger pending
  wire store_evt = storing && rd_valid && (oneshot ? shot : due);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      due <= 1'b0;
      shot <= 1'b0;
    end else begin
      // [RULE9] timer paces storage at the interval
      if (expire) begin
        due <= 1'b1;
      end else if (store_evt || !storing) begin
        due <= 1'b0;
      end
      // [RULE10] key press stores one reading
      // [RULE11] external pulse stores one reading
      if (storing && oneshot && (key_evt || ext_evt)) begin
        shot <= 1'b1;
      end else if (store_evt || !storing) begin
        shot <= 1'b0;
      end
    end
  end

  // short period: set wins over clear on a new start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_period <= 1'b0;
    end else if (start_ok) begin
      // [RULE25] high resolution under 40 ms
      short_period <= !oneshot && meas.res >= RSR_SLOW_RES_MIN && ivl < RSR_SLOW_MS;
    end else if (expire && due) begin
      // [RULE12] core too slow, keep storing as readings come
      short_period <= 1'b1;
    end else if (cmd[RSR_C_OPEN]) begin
      short_period <= 1'b0;
    end
  end

  // main state machine
  wire at_end = (wr_ptr == lim - 1'b1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= RSR_IDLE;
    end else begin
      case (state)
        RSR_IDLE: begin
          if (cmd[RSR_C_OPEN]) begin
            state <= RSR_CFG;
          end
        end
        RSR_CFG: begin
          // [RULE7] reset before confirm aborts
          if (cmd[RSR_C_RESET]) begin
            state <= RSR_IDLE;
          // [RULE5] continuous refused at high speed
          end else if (cmd[RSR_C_ENTER] && !(hs && size == '0)) begin
            state <= RSR_ARMED;
          end
        end
        RSR_ARMED: begin
          // [RULE6] invalid high speed leaves store mode
          if (start_req) begin
            state <= hs_bad ? RSR_IDLE : RSR_STORING;
          // [RULE14] function key disables store
          end else if (cmd[RSR_C_FUNC] && !recall_on) begin
            state <= RSR_IDLE;
          end
        end
        RSR_STORING: begin
          if (cmd[RSR_C_FUNC] && !recall_on) begin
            state <= RSR_IDLE;
          // [RULE2] stop once size reached
          end else if (store_evt && at_end && size != '0) begin
            state <= RSR_FULL;
          end
        end
        RSR_FULL: begin
          if (cmd[RSR_C_FUNC] && !recall_on) begin
            state <= RSR_IDLE;
          end
        end
        default: begin
          state <= RSR_IDLE;
        end
      endcase
    end
  end

  // configuration registers, writable only while configuring
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ivl <= RSR_IVL_RST;
      size <= RSR_SIZE_RST;
    end else if (state == RSR_CFG) begin
      // [RULE23] interval limited to 999.999 s
      if (wr_ivl) begin
        ivl <= (hwdata[RSR_IVL_W-1:0] > RSR_IVL_MAX) ? RSR_IVL_MAX : hwdata[RSR_IVL_W-1:0];
      end
      // [RULE4] oversize entry clamps to depth
      if (wr_size) begin
        size <= (hwdata[31:0] > 32'(DEPTH)) ? DEPTH_L : hwdata[RSR_LOC_W-1:0];
      end
    end
  end

  // storage and statistics
  rsr_reading_t old;
  assign old = mem[wr_ptr];
  wire drop_old = (filled == DEPTH_L) && !old.ovr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= '0;
      filled <= '0;
      last_loc <= '0;
      sum <= '0;
      cnt <= '0;
      max_v <= '0;
      min_v <= '0;
      max_loc <= '0;
      min_loc <= '0;
      capt <= '0;
      shown_reading <= '0;
    end else if (start_ok) begin
      // [RULE13] restart at location 1, data kept
      wr_ptr <= '0;
      filled <= '0;
      sum <= '0;
      cnt <= '0;
      max_loc <= '0;
      min_loc <= '0;
      // [RULE15] range and settings frozen at start
      capt <= meas;
    end else if (store_evt) begin
      // [RULE3] ring wraps to location 1
      wr_ptr <= at_end ? '0 : wr_ptr + 1'b1;
      last_loc <= wr_ptr + 1'b1;
      shown_reading <= rd;
      if (filled != DEPTH_L) begin
        filled <= filled + 1'b1;
      end
      // [RULE20] overrange kept out of sum and count
      // [RULE21] statistics follow each stored reading
      // signed zeros keep the sum arithmetic signed
      sum <= sum + (rd.ovr ? RSR_SUM_W'(0) : RSR_SUM_W'(rd.value))
                 - (drop_old ? RSR_SUM_W'(old.value) : RSR_SUM_W'(0));
      cnt <= cnt + (rd.ovr ? '0 : ONE_L) - (drop_old ? ONE_L : '0);
      if (!rd.ovr && (max_loc == '0 || rd.value > max_v)) begin
        max_v <= rd.value;
        max_loc <= wr_ptr + 1'b1;
      end
      if (!rd.ovr && (min_loc == '0 || rd.value < min_v)) begin
        min_v <= rd.value;
        min_loc <= wr_ptr + 1'b1;
      end
    end
  end

  // reading memory, flip-flops without reset
  always_ff @(posedge hclk) begin
    if (store_evt) begin
      mem[wr_ptr] <= rd;
    end
  end

  // recall navigation
  logic [RSR_LOC_W-1:0] top;
  assign top = (filled == '0) ? ONE_L : filled;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      recall_on <= 1'b0;
      location_prompt <= ONE_L;
      sel <= RSR_S_NORMAL;
      ent <= '0;
    end else if (cmd[RSR_C_RESET]) begin
      recall_on <= 1'b0;
    end else if (cmd[RSR_C_RECALL]) begin
      // [RULE16] default to last stored location
      recall_on <= 1'b1;
      location_prompt <= (last_loc == '0) ? ONE_L : last_loc;
      sel <= RSR_S_NORMAL;
    end else if (recall_on) begin
      if (wr_loc) begin
        // [RULE17] clamp to location set by size
        if (hwdata[31:0] > 32'(lim)) begin
          location_prompt <= lim;
        end else begin
          location_prompt <= (hwdata[RSR_LOC_W-1:0] == '0) ? ONE_L : hwdata[RSR_LOC_W-1:0];
        end
        sel <= RSR_S_NORMAL;
      end else if (wr_sel) begin
        // [RULE22] selector 0 opens settings list
        sel <= (hwdata[2:0] > RSR_S_NORMAL) ? RSR_S_NORMAL : hwdata[2:0];
        ent <= '0;
      end else if (cmd[RSR_C_NORMAL]) begin
        sel <= RSR_S_NORMAL;
      end else if (sel == RSR_S_STATUS && (cmd[RSR_C_UP] || cmd[RSR_C_DOWN])) begin
        // [RULE22] up and down walk the entries
        if (cmd[RSR_C_UP]) begin
          ent <= (ent == RSR_ENTRIES - 1'b1) ? '0 : ent + 1'b1;
        end else begin
          ent <= (ent == '0) ? RSR_ENTRIES - 1'b1 : ent - 1'b1;
        end
      end else if (cmd[RSR_C_UP]) begin
        // [RULE18] wrap past highest filled
        location_prompt <= (location_prompt >= top) ? ONE_L : location_prompt + 1'b1;
        sel <= RSR_S_NORMAL;
      end else if (cmd[RSR_C_DOWN]) begin
        // [RULE18] wrap below location 1
        location_prompt <= (location_prompt <= ONE_L) ? top : location_prompt - 1'b1;
        sel <= RSR_S_NORMAL;
      end
    end
  end

  // captured settings entry
  function automatic logic [31:0] entry(input rsr_meas_t c, input logic [3:0] i);
    case (i)
      4'h0: entry = {28'h0, c.func};
      4'h1: entry = {27'h0, c.bus_addr};
      4'h2: entry = {31'h0, c.freq};
      4'h3: entry = {31'h0, c.mux};
      4'h4: entry = {31'h0, c.scale_offset_math};
      4'h5: entry = c.m_val;
      4'h6: entry = c.b_val;
      4'h7: entry = c.ref_val;
      4'h8: entry = {25'h0, c.filter};
      4'h9: entry = {31'h0, c.zero_on};
      default: entry = c.zero_val;
    endcase
  endfunction

  // recall view: value and companion word
  logic signed [RSR_SUM_W-1:0] mean_reading;
  logic [31:0] view_data, view_aux;
  rsr_reading_t cur;
  assign cur = mem[location_prompt - 1'b1];
  always_comb begin
    // if, not ?:, so the divide stays signed for negative sums
    mean_reading = '0;
    if (cnt != '0) begin
      mean_reading = sum / $signed(RSR_SUM_W'(cnt));
    end
    view_data = 32'(cur.value);
    view_aux = {20'h0, capt.range, location_prompt};
    // [RULE19] max and min with their locations
    if (sel == RSR_S_MAX) begin
      view_data = 32'(max_v);
      view_aux = {20'h0, capt.range, max_loc};
    end else if (sel == RSR_S_MIN) begin
      view_data = 32'(min_v);
      view_aux = {20'h0, capt.range, min_loc};
    end else if (sel == RSR_S_MEAN) begin
      // [RULE20] mean shown with count used
      view_data = 32'(mean_reading);
      view_aux = {20'h0, capt.range, cnt};
    end else if (sel == RSR_S_STATUS) begin
      view_data = entry(capt, ent);
      view_aux = {28'h0, ent};
    end else if (cur.ovr) begin
      view_aux[31] = 1'b1;
    end
  end

  // read data registered in address phase, ready in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == RSR_A_IVL) begin
        hrdata <= 32'(ivl);
      end else if (haddr[7:0] == RSR_A_SIZE) begin
        hrdata <= 32'(size);
      end else if (haddr[7:0] == RSR_A_STAT) begin
        hrdata <= {4'h0, filled, last_loc, 3'h0, short_period,
                   recall_lamp, store_lamp, 1'b0, state};
      end else if (haddr[7:0] == RSR_A_LOC) begin
        hrdata <= 32'(location_prompt);
      end else if (haddr[7:0] == RSR_A_SEL) begin
        hrdata <= 32'(sel);
      end else if (haddr[7:0] == RSR_A_DATA) begin
        hrdata <= view_data;
      end else if (haddr[7:0] == RSR_A_AUX) begin
        hrdata <= view_aux;
      end else begin
        hrdata <= 32'h0;
      end
    end
  end

  // blink time base from the millisecond tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt <= 8'h00;
      blink <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == 8'(RSR_BLINK_MS - 1)) begin
        blink_cnt <= 8'h00;
        blink <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 8'h01;
      end
    end
  end

  // indicators
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      store_lamp <= 1'b0;
      recall_lamp <= 1'b0;
    end else begin
      // [RULE8] blink while armed
      // [RULE9] flash storing, steady full
      store_lamp <= (state == RSR_ARMED || storing) ? blink : (state == RSR_FULL);
      // [RULE16] recall lamp follows recall mode
      recall_lamp <= recall_on;
    end
  end
endmodule
